// ---- rtl/link_pkg.sv ----
// Shared constants, carrier types and CRC helpers for the single-wire framing block
package link_pkg;
  // ROM-level commands
  localparam logic [7:0] ROM_READ_CMD = 8'h33;
  localparam logic [7:0] ROM_MATCH_CMD = 8'h55;
  localparam logic [7:0] ROM_SKIP_CMD = 8'hCC;
  // Function commands
  localparam logic [7:0] FN_WRITE_CMD = 8'hCC;
  localparam logic [7:0] FN_READ_CMD = 8'h33;
  localparam logic [7:0] FN_CONVERT_CMD = 8'h44;
  localparam logic [7:0] FN_SOFT_RESET_CMD = 8'h82;
  // Reflected generator forms, shifted LSB first
  localparam logic [7:0] CRC8_POLY_REFL = 8'h8C;
  localparam logic [15:0] CRC16_POLY_REFL = 16'hA001;
  localparam logic [7:0] CRC8_INIT = 8'h00;
  localparam logic [15:0] CRC16_INIT = 16'h0000;
  // Identification code layout
  localparam int ROM_BODY_BITS = 56;
  localparam int FAMILY_LSB = 0;
  localparam int SERIAL_LSB = 8;
  localparam int CHECK_LSB = 56;
  localparam logic [7:0] ROM_LAST_BYTE = 8'h07;

  typedef struct packed {
    logic [7:0] data;
    logic conv_tag;
  } tx_item_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  function automatic logic [7:0] crc8_rom(input logic [55:0] body);
    logic [7:0] c;
    logic fb;
    c = CRC8_INIT;
    for (int i = 0; i < ROM_BODY_BITS; i++) begin
      fb = c[0] ^ body[i];
      c = c >> 1;
      if (fb) begin
        c = c ^ CRC8_POLY_REFL;
      end
    end
    return c;
  endfunction

  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    logic fb;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      fb = c[0] ^ d[i];
      c = c >> 1;
      if (fb) begin
        c = c ^ CRC16_POLY_REFL;
      end
    end
    return c;
  endfunction
endpackage

// ---- rtl/skid_buf2.sv ----
// Two-entry buffer on the transmit byte path, head entry drives the outputs
module skid_buf2
  import link_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic flush_in,
  // Fill side
  input wire logic in_valid_in,
  input wire tx_item_t in_item_in,
  output logic in_ready_out,
  // Drain side
  output logic out_valid_out,
  output tx_item_t out_item_out,
  input wire logic out_ready_in
);
  tx_item_t head_r, head_nxt, tail_r, tail_nxt;
  logic head_v_r, head_v_nxt, tail_v_r, tail_v_nxt;
  logic push, pop;

  always_comb begin
    push = in_valid_in & ~tail_v_r;
    pop = head_v_r & out_ready_in;
    head_nxt = head_r;
    tail_nxt = tail_r;
    head_v_nxt = head_v_r;
    tail_v_nxt = tail_v_r;
    if (flush_in) begin
      head_v_nxt = 1'b0;
      tail_v_nxt = 1'b0;
    end else if (pop) begin
      if (tail_v_r) begin
        head_nxt = tail_r;
        tail_v_nxt = 1'b0;
      end else if (push) begin
        head_nxt = in_item_in;
      end else begin
        head_v_nxt = 1'b0;
      end
    end else if (push) begin
      if (!head_v_r) begin
        head_nxt = in_item_in;
        head_v_nxt = 1'b1;
      end else begin
        tail_nxt = in_item_in;
        tail_v_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      head_r <= '0;
      tail_r <= '0;
      head_v_r <= 1'b0;
      tail_v_r <= 1'b0;
    end else begin
      head_r <= head_nxt;
      tail_r <= tail_nxt;
      head_v_r <= head_v_nxt;
      tail_v_r <= tail_v_nxt;
    end
  end

  assign in_ready_out = ~tail_v_r;
  assign out_valid_out = head_v_r;
  assign out_item_out = head_r;
endmodule

// ---- rtl/wire_framer.sv ----
// Byte-level framing: identification code, register commands and command CRC
// Functional notes
// - Identification code: family byte low, 48-bit serial, check byte on top.
// - Check byte is the 8-bit CRC of the lower 56 code bits.
// - Code sent byte 0 first, each byte least significant bit first.
// - Registers written only by command 0xCC, read only by 0x33.
// - Sequences run to the end regardless of any CRC outcome.
// - Check byte generator is x^8+x^5+x^4+1 as XOR feedback shift register.
// - Command CRC covers command, address, length and all data bytes.
// - Inverted 16-bit CRC sent at sequence end, low byte first, LSB first.
// - Command CRC generator is x^16+x^15+x^2+1, cleared to zero.
// - Convert returns CRC bytes 0xCCFF; conversion starts after second byte read.
// - Length byte carries byte count minus one.
// - Each transaction starts with bus reset and presence before ROM commands.
// - Soft reset 0x82 restores configuration, answers inverted CRC, goes standby.
module wire_framer
  import link_pkg::*;
#(
  parameter logic [7:0] FAMILY_CODE = 8'h3A, // Arbitrary value
  parameter logic [47:0] SERIAL_NUM = 48'h0123456789AB // Arbitrary value
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Link front end, same clock
  input wire logic bus_reset_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  input wire logic tx_ready_in,
  // Register file port
  output reg_req_t reg_req_out,
  input wire logic [7:0] reg_rdata_in,
  // Device events
  output logic conv_start_out,
  output logic soft_reset_out
);
  typedef enum logic [13:0] {
    S_IDLE     = 14'h0001,
    S_ROM_CMD  = 14'h0002,
    S_ROM_MTCH = 14'h0004,
    S_ROM_SEND = 14'h0008,
    S_FN_CMD   = 14'h0010,
    S_FN_ADDR  = 14'h0020,
    S_FN_LEN   = 14'h0040,
    S_FN_WDATA = 14'h0080,
    S_FN_RREQ  = 14'h0100,
    S_FN_RCAP  = 14'h0200,
    S_FN_RSEND = 14'h0400,
    S_CRC_LO   = 14'h0800,
    S_CRC_HI   = 14'h1000,
    S_HALT     = 14'h2000
  } state_t;

  localparam logic [55:0] ROM_BODY = {SERIAL_NUM, FAMILY_CODE};
  localparam logic [63:0] ROM_CODE = {crc8_rom(ROM_BODY), ROM_BODY};

  state_t state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt, cmd_r, cmd_nxt, addr_r, addr_nxt, len_r, len_nxt, byte_r, byte_nxt;
  logic [15:0] crc_r, crc_nxt;
  logic match_r, match_nxt;
  reg_req_t reg_r, reg_nxt;
  logic conv_r, conv_nxt, soft_r, soft_nxt;
  logic push;
  tx_item_t push_item, head_item;
  logic buf_ready, head_valid;
  logic [7:0] rom_byte;
  assign rom_byte = ROM_CODE[cnt_r[2:0]*8 +: 8];

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    cmd_nxt = cmd_r;
    addr_nxt = addr_r;
    len_nxt = len_r;
    byte_nxt = byte_r;
    crc_nxt = crc_r;
    match_nxt = match_r;
    reg_nxt = '0;
    soft_nxt = 1'b0;
    push = 1'b0;
    push_item = '0;
    conv_nxt = head_valid & tx_ready_in & head_item.conv_tag;
    case (state_r)
      S_ROM_CMD: if (rx_valid_in) begin
        cnt_nxt = 8'h00;
        match_nxt = 1'b1;
        if (rx_data_in == ROM_READ_CMD) begin
          state_nxt = S_ROM_SEND;
        end else if (rx_data_in == ROM_MATCH_CMD) begin
          state_nxt = S_ROM_MTCH;
        end else if (rx_data_in == ROM_SKIP_CMD) begin
          state_nxt = S_FN_CMD;
        end else begin
          state_nxt = S_HALT;
        end
      end
      S_ROM_MTCH: if (rx_valid_in) begin
        match_nxt = match_r & (rx_data_in == rom_byte);
        cnt_nxt = cnt_r + 8'h01;
        if (cnt_r == ROM_LAST_BYTE) begin
          state_nxt = match_nxt ? S_FN_CMD : S_HALT;
        end
      end
      S_ROM_SEND: if (buf_ready) begin
        push = 1'b1;
        push_item.data = rom_byte;
        cnt_nxt = cnt_r + 8'h01;
        if (cnt_r == ROM_LAST_BYTE) begin
          state_nxt = S_FN_CMD;
        end
      end
      S_FN_CMD: if (rx_valid_in) begin
        cmd_nxt = rx_data_in;
        crc_nxt = crc16_byte(CRC16_INIT, rx_data_in);
        if (rx_data_in == FN_WRITE_CMD || rx_data_in == FN_READ_CMD) begin
          state_nxt = S_FN_ADDR;
        end else if (rx_data_in == FN_CONVERT_CMD) begin
          state_nxt = S_CRC_LO;
        end else if (rx_data_in == FN_SOFT_RESET_CMD) begin
          soft_nxt = 1'b1;
          state_nxt = S_CRC_LO;
        end else begin
          state_nxt = S_HALT;
        end
      end
      S_FN_ADDR: if (rx_valid_in) begin
        addr_nxt = rx_data_in;
        crc_nxt = crc16_byte(crc_r, rx_data_in);
        state_nxt = S_FN_LEN;
      end
      S_FN_LEN: if (rx_valid_in) begin
        len_nxt = rx_data_in;
        cnt_nxt = 8'h00;
        crc_nxt = crc16_byte(crc_r, rx_data_in);
        state_nxt = (cmd_r == FN_WRITE_CMD) ? S_FN_WDATA : S_FN_RREQ;
      end
      S_FN_WDATA: if (rx_valid_in) begin
        reg_nxt.wr = 1'b1;
        reg_nxt.addr = addr_r + cnt_r;
        reg_nxt.wdata = rx_data_in;
        crc_nxt = crc16_byte(crc_r, rx_data_in);
        cnt_nxt = cnt_r + 8'h01;
        if (cnt_r == len_r) begin
          state_nxt = S_CRC_LO;
        end
      end
      S_FN_RREQ: begin
        reg_nxt.rd = 1'b1;
        reg_nxt.addr = addr_r + cnt_r;
        state_nxt = S_FN_RCAP;
      end
      S_FN_RCAP: begin
        byte_nxt = reg_rdata_in;
        state_nxt = S_FN_RSEND;
      end
      S_FN_RSEND: if (buf_ready) begin
        push = 1'b1;
        push_item.data = byte_r;
        crc_nxt = crc16_byte(crc_r, byte_r);
        cnt_nxt = cnt_r + 8'h01;
        state_nxt = (cnt_r == len_r) ? S_CRC_LO : S_FN_RREQ;
      end
      S_CRC_LO: if (buf_ready) begin
        push = 1'b1;
        push_item.data = ~crc_r[7:0];
        state_nxt = S_CRC_HI;
      end
      S_CRC_HI: if (buf_ready) begin
        push = 1'b1;
        push_item.data = ~crc_r[15:8];
        push_item.conv_tag = (cmd_r == FN_CONVERT_CMD);
        state_nxt = S_IDLE;
      end
      default: begin
      end
    endcase
    if (bus_reset_in) begin
      state_nxt = S_ROM_CMD;
      push = 1'b0;
      reg_nxt = '0;
      soft_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r <= S_IDLE;
      cnt_r <= 8'h00;
      cmd_r <= 8'h00;
      addr_r <= 8'h00;
      len_r <= 8'h00;
      byte_r <= 8'h00;
      crc_r <= CRC16_INIT;
      match_r <= 1'b0;
      reg_r <= '0;
      conv_r <= 1'b0;
      soft_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      cmd_r <= cmd_nxt;
      addr_r <= addr_nxt;
      len_r <= len_nxt;
      byte_r <= byte_nxt;
      crc_r <= crc_nxt;
      match_r <= match_nxt;
      reg_r <= reg_nxt;
      conv_r <= conv_nxt;
      soft_r <= soft_nxt;
    end
  end

  skid_buf2 u_txbuf (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .flush_in(bus_reset_in),
    .in_valid_in(push),
    .in_item_in(push_item),
    .in_ready_out(buf_ready),
    .out_valid_out(head_valid),
    .out_item_out(head_item),
    .out_ready_in(tx_ready_in)
  );

  assign tx_valid_out = head_valid;
  assign tx_data_out = head_item.data;
  assign reg_req_out = reg_r;
  assign conv_start_out = conv_r;
  assign soft_reset_out = soft_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  property p_rom_family;
    push && state_r == S_ROM_SEND && cnt_r == 8'h00 |-> push_item.data == FAMILY_CODE;
  endproperty
  a_rom_family: assert property (p_rom_family) else $error("first code byte not family");
  property p_rom_check;
    push && state_r == S_ROM_SEND && cnt_r == ROM_LAST_BYTE |-> push_item.data == crc8_rom(ROM_BODY);
  endproperty
  a_rom_check: assert property (p_rom_check) else $error("check byte wrong");
  property p_rom_order;
    push && state_r == S_ROM_SEND && !bus_reset_in |=> cnt_r == $past(cnt_r) + 8'h01;
  endproperty
  a_rom_order: assert property (p_rom_order) else $error("code bytes out of order");
  property p_wr_only_write;
    reg_req_out.wr |-> cmd_r == FN_WRITE_CMD && !reg_req_out.rd;
  endproperty
  a_wr_only_write: assert property (p_wr_only_write) else $error("write without write command");
  property p_rd_capture;
    reg_req_out.rd |-> cmd_r == FN_READ_CMD ##1 byte_r == $past(reg_rdata_in) || $past(bus_reset_in);
  endproperty
  a_rd_capture: assert property (p_rd_capture) else $error("read data not captured");
  property p_crc_lo;
    push && state_r == S_CRC_LO |-> push_item.data == ~crc_r[7:0] ##1 state_r == S_CRC_HI;
  endproperty
  a_crc_lo: assert property (p_crc_lo) else $error("inverted CRC low byte wrong");
  property p_crc_clear;
    state_r == S_FN_CMD && rx_valid_in && !bus_reset_in |=> crc_r == crc16_byte(CRC16_INIT, $past(rx_data_in));
  endproperty
  a_crc_clear: assert property (p_crc_clear) else $error("CRC not restarted");
  property p_no_abort;
    state_r == S_CRC_LO && !bus_reset_in |=> state_r inside {S_CRC_LO, S_CRC_HI};
  endproperty
  a_no_abort: assert property (p_no_abort) else $error("sequence aborted before CRC");
  property p_conv_start;
    head_valid && tx_ready_in && head_item.conv_tag |=> conv_start_out ##1 !conv_start_out;
  endproperty
  a_conv_start: assert property (p_conv_start) else $error("conversion start not one pulse");
  property p_soft;
    state_r == S_FN_CMD && rx_valid_in && rx_data_in == FN_SOFT_RESET_CMD && !bus_reset_in
      |=> soft_reset_out && state_r == S_CRC_LO;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset not taken");
  property p_idle_wait;
    state_r == S_IDLE && !bus_reset_in |=> state_r == S_IDLE;
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("left standby without bus reset");

  c_match: cover property (state_r == S_ROM_MTCH ##[1:200] state_r == S_FN_CMD);
  c_convert: cover property (conv_start_out);
  c_read: cover property (state_r == S_FN_RSEND ##[1:300] state_r == S_CRC_HI);
  c_stall: cover property (!buf_ready && state_r == S_CRC_LO);
endmodule

// ---- verif/master_model.sv ----
// Behavioural bus master front end that paces the framing block
module master_model
  import link_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Pacing
  input wire logic slow_in,
  // Byte streams
  output logic tx_ready_out,
  output logic bus_reset_out,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  integer seed = 46873;

  initial begin
    tx_ready_out = 1'b0;
    bus_reset_out = 1'b0;
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
  end

  // Random acceptance, long stalls in slow mode
  always @(negedge clk_in) begin
    tx_ready_out <= slow_in ? (($random(seed) & 7) == 0) : (($random(seed) & 3) != 0);
  end

  // One-cycle bus reset pulse opens every transaction
  task automatic bus_reset();
    @(negedge clk_in);
    bus_reset_out <= 1'b1;
    @(negedge clk_in);
    bus_reset_out <= 1'b0;
  endtask

  // Idle data shows the inverse of the last byte
  task automatic send(input logic [7:0] b);
    @(negedge clk_in);
    rx_valid_out <= 1'b1;
    rx_data_out <= b;
    @(negedge clk_in);
    rx_valid_out <= 1'b0;
    rx_data_out <= ~b;
  endtask

  // Strong pullup at once after the convert CRC, bus quiet for the conversion
  task automatic strong_pullup(input int n);
    @(negedge clk_in);
    rx_valid_out <= 1'b0;
    bus_reset_out <= 1'b0;
    repeat (n) @(negedge clk_in);
  endtask
endmodule

// ---- verif/wire_framer_tb.sv ----
// Self-checking bench for the single-wire framing block
module wire_framer_tb
  import link_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] FAM = 8'h5B; // Arbitrary value
  localparam logic [47:0] SER = 48'hC0FFEE123456; // Arbitrary value
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic slow = 1'b0;
  logic bus_reset_in, rx_valid_in, tx_valid_out, tx_ready_in, conv_start_out, soft_reset_out;
  logic [7:0] rx_data_in, tx_data_out, ra, rl;
  logic [7:0] reg_rdata_in = 8'h00;
  reg_req_t reg_req_out, seen;
  int err_count = 0;
  int comparisons = 0;
  int convs = 0;
  int softs = 0;
  integer seed = 46873;
  logic took_r = 1'b0;
  logic [7:0] exp_tx[$];
  reg_req_t exp_req[$];
  logic [7:0] wd[256];
  logic [63:0] rom;
  logic [15:0] rc;

  always #20 clk_in = ~clk_in;

  wire_framer #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER)) dut_u (.clk_in(clk_in), .nrst_in(nrst_in),
    .bus_reset_in(bus_reset_in), .rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in),
    .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out), .tx_ready_in(tx_ready_in),
    .reg_req_out(reg_req_out), .reg_rdata_in(reg_rdata_in), .conv_start_out(conv_start_out),
    .soft_reset_out(soft_reset_out));
  master_model pm_u (.clk_in(clk_in), .nrst_in(nrst_in), .slow_in(slow), .tx_ready_out(tx_ready_in),
    .bus_reset_out(bus_reset_in), .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in));

  // Register file stand-in: data is a function of the address
  always @(negedge clk_in) begin
    reg_rdata_in <= reg_req_out.addr ^ 8'hA5;
  end

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d, input logic [15:0] p);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ p) : (r >> 1);
    end
    return r;
  endfunction

  task automatic chk_tx(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_req(input string n, input reg_req_t e, input reg_req_t g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic give_verdict();
    $display("Mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Result watcher: oldest note against each accepted byte and each register request
  always @(posedge clk_in) begin
    if (nrst_in) begin
      if ((tx_valid_out & tx_ready_in) === 1'b1) begin
        chk_tx("tx_byte", exp_tx.size() ? exp_tx.pop_front() : ~tx_data_out, tx_data_out);
      end
      if (reg_req_out.wr === 1'b1 || reg_req_out.rd === 1'b1) begin
        seen = reg_req_out;
        if (seen.rd) seen.wdata = 8'h00;
        chk_req("reg_req", exp_req.size() ? exp_req.pop_front() : ~seen, seen);
      end
      if (conv_start_out === 1'b1) begin
        chk_tx("conv_after_crc", 8'h01, {7'h00, took_r});
        convs++;
      end
      if (soft_reset_out === 1'b1) softs++;
      took_r <= (tx_valid_out & tx_ready_in) === 1'b1 && tx_data_out === 8'hCC;
    end
  end

  task automatic drain();
    int n;
    n = 0;
    while ((exp_tx.size() || exp_req.size()) && n < 2000) begin
      @(posedge clk_in);
      n++;
    end
    if (n == 2000) begin
      err_count++;
      $display("Error drain expected 0 seen %0d", exp_tx.size());
      give_verdict();
    end
    repeat (4) @(posedge clk_in);
  endtask

  // Mode 0 read code, 1 match, 2 skip, 3 match with a wrong code
  task automatic rom_phase(input int mode);
    pm_u.bus_reset();
    if (mode == 0) begin
      for (int i = 0; i < 8; i++) exp_tx.push_back(rom[8*i+:8]);
      pm_u.send(ROM_READ_CMD);
      drain();
    end else if (mode == 2) begin
      pm_u.send(ROM_SKIP_CMD);
    end else begin
      pm_u.send(ROM_MATCH_CMD);
      for (int i = 0; i < 8; i++) pm_u.send(mode == 1 ? rom[8*i+:8] : ~rom[8*i+:8]);
    end
  endtask

  task automatic fn_cmd(input logic [7:0] cmd, input logic [7:0] addr, input logic [7:0] len);
    logic [15:0] c;
    logic [7:0] d;
    logic rw;
    rw = cmd == FN_WRITE_CMD || cmd == FN_READ_CMD;
    c = crc_upd(16'h0000, cmd, 16'hA001);
    if (rw) begin
      c = crc_upd(crc_upd(c, addr, 16'hA001), len, 16'hA001);
      for (int k = 0; k <= len; k++) begin
        d = cmd == FN_READ_CMD ? (addr + k[7:0]) ^ 8'hA5 : 8'($random(seed));
        wd[k] = d;
        exp_req.push_back('{cmd == FN_WRITE_CMD, cmd == FN_READ_CMD, addr + k[7:0],
          cmd == FN_WRITE_CMD ? d : 8'h00});
        if (cmd == FN_READ_CMD) exp_tx.push_back(d);
        c = crc_upd(c, d, 16'hA001);
      end
    end
    if (cmd == FN_CONVERT_CMD) c = 16'h3300;
    exp_tx.push_back(~c[7:0]);
    exp_tx.push_back(~c[15:8]);
    pm_u.send(cmd);
    if (rw) begin
      pm_u.send(addr);
      pm_u.send(len);
    end
    if (cmd == FN_WRITE_CMD) begin
      for (int k = 0; k <= len; k++) pm_u.send(wd[k]);
    end
    drain();
  endtask

  initial begin
    rom = {8'h00, SER, FAM};
    rc = 16'h0000;
    for (int i = 0; i < 7; i++) rc = crc_upd(rc, rom[8*i+:8], 16'h008C);
    rom[63:56] = rc[7:0];
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
    nrst_in = 1'b1;
    pm_u.send(ROM_READ_CMD);
    repeat (20) @(posedge clk_in);
    @(negedge clk_in);
    chk_tx("idle_tx_valid", 8'h00, {7'h00, tx_valid_out});
    rom_phase(0);
    fn_cmd(FN_READ_CMD, 8'h08, 8'h01);
    slow = 1'b1;
    rom_phase(0);
    slow = 1'b0;
    rom_phase(2);
    fn_cmd(FN_WRITE_CMD, 8'hFF, 8'h01);
    rom_phase(1);
    fn_cmd(FN_CONVERT_CMD, 8'h00, 8'h00);
    pm_u.strong_pullup(100);
    chk_tx("conv_count", 8'h01, convs[7:0]);
    rom_phase(3);
    pm_u.send(FN_CONVERT_CMD);
    repeat (30) @(posedge clk_in);
    chk_tx("conv_count_mismatch", 8'h01, convs[7:0]);
    rom_phase(2);
    fn_cmd(FN_SOFT_RESET_CMD, 8'h00, 8'h00);
    chk_tx("soft_reset_count", 8'h01, softs[7:0]);
    for (int i = 0; i < 4; i++) begin
      slow = i[0];
      ra = 8'($random(seed));
      rl = 8'($random(seed)) & 8'h03;
      rom_phase(2);
      fn_cmd(FN_WRITE_CMD, ra, rl);
      rom_phase(i[1] ? 1 : 2);
      fn_cmd(FN_READ_CMD, ra, rl);
    end
    give_verdict();
  end
endmodule
